// [design/pdc_pkg.sv]
// Register map, field layout and reset values of the divider configuration block
package pdc_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int LS_W = 20;
	localparam int HS_W = 3;
	localparam int HS_CNT_W = 4;
	localparam int RATIO_W = 21;

	// Register offsets
	localparam logic [7:0] OFS_OUT1_DIV_UPPER = 8'h1f;
	localparam logic [7:0] OFS_OUT1_DIV_MIDDLE = 8'h20;
	localparam logic [7:0] OFS_OUT1_DIV_LOW = 8'h21;
	localparam logic [7:0] OFS_OUT2_DIV_UPPER = 8'h22;
	localparam logic [7:0] OFS_OUT2_DIV_MIDDLE = 8'h23;
	localparam logic [7:0] OFS_OUT2_DIV_LOW = 8'h24;
	localparam logic [7:0] OFS_FEEDBACK_HS_AND_UPPER = 8'h28;
	localparam logic [7:0] OFS_FEEDBACK_DIV_MIDDLE = 8'h29;

	// Reset values
	localparam logic [7:0] RST_OUT1_DIV_UPPER = 8'h00;
	localparam logic [7:0] RST_OUT1_DIV_MIDDLE = 8'h00;
	localparam logic [7:0] RST_OUT1_DIV_LOW = 8'h31;
	localparam logic [7:0] RST_OUT2_DIV_UPPER = 8'h00;
	localparam logic [7:0] RST_OUT2_DIV_MIDDLE = 8'h00;
	localparam logic [7:0] RST_OUT2_DIV_LOW = 8'h31;
	localparam logic [7:0] RST_FEEDBACK_HS_AND_UPPER = 8'hc0;
	localparam logic [7:0] RST_FEEDBACK_DIV_MIDDLE = 8'h00;

	// Writable bits per register kind
	localparam logic [7:0] MASK_UPPER = 8'h0f;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_FEEDBACK_HS_AND_UPPER = 8'hef;

	// Field positions
	localparam int UPPER_MSB = 3;
	localparam int HS_MSB = 7;
	localparam int HS_LSB = 5;

	// High-speed code 0 divides by 4, so terminal count is code plus 3
	localparam logic [HS_CNT_W-1:0] HS_TERM_BIAS = 4'h3;
	localparam logic [RATIO_W-1:0] RATIO_BIAS = 21'h00001;
endpackage

// [design/pdc_count_div.sv]
// Counting divider with a terminal count that is taken up only at wrap
`timescale 1ns/100ps
`default_nettype none
module pdc_count_div
#(
	parameter int W = 20
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_en,
	input wire logic [W-1:0] i_term,
	output logic o_tick
);
	typedef struct packed {
		logic [W-1:0] count;
		logic [W-1:0] term;
		logic tick;
	} pdc_cnt_s;

	pdc_cnt_s state;
	pdc_cnt_s next_state;

	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		if (i_en)
		begin
			// New term only at wrap, so a write never cuts a period short
			if (state.count >= state.term)
			begin
				next_state.count = '0;
				next_state.term = i_term;
				next_state.tick = 1'b1;
			end
			else
			begin
				next_state.count = state.count + W'(1);
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign o_tick = state.tick;
endmodule
`default_nettype wire

// [design/pdc_hs_div.sv]
// Feedback high-speed divider, ratios 4 to 11 from a 3-bit code
`timescale 1ns/100ps
`default_nettype none
module pdc_hs_div
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_en,
	input wire logic [pdc_pkg::HS_W-1:0] i_code,
	output logic o_tick
);
	typedef struct packed {
		logic [pdc_pkg::HS_CNT_W-1:0] count;
		logic tick;
	} pdc_hs_s;

	pdc_hs_s state;
	pdc_hs_s next_state;
	logic [pdc_pkg::HS_CNT_W-1:0] term;

	assign term = {1'b0, i_code} + pdc_pkg::HS_TERM_BIAS;

	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		if (i_en)
		begin
			if (state.count >= term)
			begin
				next_state.count = '0;
				next_state.tick = 1'b1;
			end
			else
			begin
				next_state.count = state.count + pdc_pkg::HS_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign o_tick = state.tick;
endmodule
`default_nettype wire

// [design/pll_divider_config.sv]
// Divider configuration registers and output and feedback divider chains
// Summary of operation
// - First output clock divided by 20-bit field over upper, middle, low registers.
// - Second output clock divided by its own 20-bit field, three registers.
// - Output division ratio is field plus one: 1, 2, then even ratios.
// - Feedback high-speed code in bits 7:5 selects ratio 4 to 11.
// - Feedback low-speed divider output feeds phase detector; upper and middle split.
// - Reset loads output low bytes with 0x31, output upper and middle and feedback middle bytes zero.
// - Reset loads feedback high-speed and upper register with 0xc0.
`timescale 1ns/100ps
`default_nettype none
module pll_divider_config
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [pdc_pkg::ADDR_W-1:0] i_reg_addr,
	input wire logic [pdc_pkg::DATA_W-1:0] i_reg_wdata,
	output logic [pdc_pkg::DATA_W-1:0] o_reg_rdata,
	output logic o_reg_rvalid,
	output logic o_reg_hit,
	input wire logic i_output_hs_tick,
	input wire logic i_vco_tick,
	input wire logic [pdc_pkg::DATA_W-1:0] i_feedback_lowspeed_low,
	output logic o_first_output_clock,
	output logic o_second_output_clock,
	output logic o_phase_detector_tick,
	output logic [pdc_pkg::RATIO_W-1:0] o_first_output_ratio,
	output logic [pdc_pkg::RATIO_W-1:0] o_second_output_ratio,
	output logic o_first_output_setting_legal,
	output logic o_second_output_setting_legal
);
	typedef struct packed {
		logic [7:0] out1_div_upper;
		logic [7:0] out1_div_middle;
		logic [7:0] out1_div_low;
		logic [7:0] out2_div_upper;
		logic [7:0] out2_div_middle;
		logic [7:0] out2_div_low;
		logic [7:0] feedback_hs_and_upper;
		logic [7:0] feedback_div_middle;
		logic [pdc_pkg::DATA_W-1:0] rdata;
		logic rvalid;
		logic [pdc_pkg::RATIO_W-1:0] ratio1;
		logic [pdc_pkg::RATIO_W-1:0] ratio2;
		logic legal1;
		logic legal2;
	} pdc_state_s;

	pdc_state_s state;
	pdc_state_s next_state;

	logic [pdc_pkg::LS_W-1:0] first_output_lowspeed_divider;
	logic [pdc_pkg::LS_W-1:0] second_output_lowspeed_divider;
	logic [pdc_pkg::LS_W-1:0] feedback_lowspeed_divider;
	logic [pdc_pkg::HS_W-1:0] feedback_highspeed_divider;
	logic feedback_lowspeed_stage;
	logic addr_hit;
	logic [pdc_pkg::DATA_W-1:0] read_value;

	assign first_output_lowspeed_divider = {
		state.out1_div_upper[pdc_pkg::UPPER_MSB:0],
		state.out1_div_middle,
		state.out1_div_low
	};

	assign second_output_lowspeed_divider = {
		state.out2_div_upper[pdc_pkg::UPPER_MSB:0],
		state.out2_div_middle,
		state.out2_div_low
	};

	// feedback field, low byte from neighbour
	assign feedback_lowspeed_divider = {
		state.feedback_hs_and_upper[pdc_pkg::UPPER_MSB:0],
		state.feedback_div_middle,
		i_feedback_lowspeed_low
	};

	assign feedback_highspeed_divider =
		state.feedback_hs_and_upper[pdc_pkg::HS_MSB:pdc_pkg::HS_LSB];

	always_comb
	begin
		addr_hit = 1'b1;
		read_value = '0;
		unique case (i_reg_addr)
			pdc_pkg::OFS_OUT1_DIV_UPPER:
				read_value = state.out1_div_upper;
			pdc_pkg::OFS_OUT1_DIV_MIDDLE:
				read_value = state.out1_div_middle;
			pdc_pkg::OFS_OUT1_DIV_LOW:
				read_value = state.out1_div_low;
			pdc_pkg::OFS_OUT2_DIV_UPPER:
				read_value = state.out2_div_upper;
			pdc_pkg::OFS_OUT2_DIV_MIDDLE:
				read_value = state.out2_div_middle;
			pdc_pkg::OFS_OUT2_DIV_LOW:
				read_value = state.out2_div_low;
			pdc_pkg::OFS_FEEDBACK_HS_AND_UPPER:
				read_value = state.feedback_hs_and_upper;
			pdc_pkg::OFS_FEEDBACK_DIV_MIDDLE:
				read_value = state.feedback_div_middle;
			default:
				addr_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		next_state = state;
		next_state.rvalid = 1'b0;
		if (i_reg_rd)
		begin
			// Unmapped offsets read as zero
			next_state.rdata = read_value;
			next_state.rvalid = 1'b1;
		end
		if (i_reg_wr)
		begin
			unique case (i_reg_addr)
				pdc_pkg::OFS_OUT1_DIV_UPPER:
					next_state.out1_div_upper = i_reg_wdata & pdc_pkg::MASK_UPPER;
				pdc_pkg::OFS_OUT1_DIV_MIDDLE:
					next_state.out1_div_middle = i_reg_wdata & pdc_pkg::MASK_FULL;
				pdc_pkg::OFS_OUT1_DIV_LOW:
					next_state.out1_div_low = i_reg_wdata & pdc_pkg::MASK_FULL;
				pdc_pkg::OFS_OUT2_DIV_UPPER:
					next_state.out2_div_upper = i_reg_wdata & pdc_pkg::MASK_UPPER;
				pdc_pkg::OFS_OUT2_DIV_MIDDLE:
					next_state.out2_div_middle = i_reg_wdata & pdc_pkg::MASK_FULL;
				pdc_pkg::OFS_OUT2_DIV_LOW:
					next_state.out2_div_low = i_reg_wdata & pdc_pkg::MASK_FULL;
				pdc_pkg::OFS_FEEDBACK_HS_AND_UPPER:
					next_state.feedback_hs_and_upper =
						i_reg_wdata & pdc_pkg::MASK_FEEDBACK_HS_AND_UPPER;
				pdc_pkg::OFS_FEEDBACK_DIV_MIDDLE:
					next_state.feedback_div_middle = i_reg_wdata & pdc_pkg::MASK_FULL;
				default:
				begin
				end
			endcase
		end
		next_state.ratio1 = {1'b0, first_output_lowspeed_divider} + pdc_pkg::RATIO_BIAS;
		next_state.ratio2 = {1'b0, second_output_lowspeed_divider} + pdc_pkg::RATIO_BIAS;
		// flag nonzero even settings the host should avoid
		next_state.legal1 = (first_output_lowspeed_divider == '0)
			|| first_output_lowspeed_divider[0];
		next_state.legal2 = (second_output_lowspeed_divider == '0)
			|| second_output_lowspeed_divider[0];
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			state.out1_div_upper <= pdc_pkg::RST_OUT1_DIV_UPPER;
			state.out1_div_middle <= pdc_pkg::RST_OUT1_DIV_MIDDLE;
			state.out1_div_low <= pdc_pkg::RST_OUT1_DIV_LOW;
			state.out2_div_upper <= pdc_pkg::RST_OUT2_DIV_UPPER;
			state.out2_div_middle <= pdc_pkg::RST_OUT2_DIV_MIDDLE;
			state.out2_div_low <= pdc_pkg::RST_OUT2_DIV_LOW;
			state.feedback_hs_and_upper <= pdc_pkg::RST_FEEDBACK_HS_AND_UPPER;
			state.feedback_div_middle <= pdc_pkg::RST_FEEDBACK_DIV_MIDDLE;
			state.rdata <= '0;
			state.rvalid <= 1'b0;
			state.ratio1 <= '0;
			state.ratio2 <= '0;
			state.legal1 <= 1'b0;
			state.legal2 <= 1'b0;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Per-channel view so both outputs share one divider description
	logic [pdc_pkg::LS_W-1:0] out_field [2];
	logic out_tick [2];

	assign out_field[0] = first_output_lowspeed_divider;
	assign out_field[1] = second_output_lowspeed_divider;

	for (genvar ch = 0; ch < 2; ch++)
	begin
		pdc_count_div #(
			.W(pdc_pkg::LS_W)
		) u_out_div (
			.i_clk(i_clk),
			.i_rst_n(i_rst_n),
			.i_en(i_output_hs_tick),
			.i_term(out_field[ch]),
			.o_tick(out_tick[ch])
		);
	end

	pdc_hs_div u_fb_hs_div (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_en(i_vco_tick),
		.i_code(feedback_highspeed_divider),
		.o_tick(feedback_lowspeed_stage)
	);

	pdc_count_div #(
		.W(pdc_pkg::LS_W)
	) u_fb_ls_div (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_en(feedback_lowspeed_stage),
		.i_term(feedback_lowspeed_divider),
		.o_tick(o_phase_detector_tick)
	);

	assign o_reg_rdata = state.rdata;
	assign o_reg_rvalid = state.rvalid;
	assign o_reg_hit = addr_hit;
	assign o_first_output_clock = out_tick[0];
	assign o_second_output_clock = out_tick[1];
	assign o_first_output_ratio = state.ratio1;
	assign o_second_output_ratio = state.ratio2;
	assign o_first_output_setting_legal = state.legal1;
	assign o_second_output_setting_legal = state.legal2;
endmodule
`default_nettype wire

// [dv/pdc_assertions.sv]
// Checker of the register port and divider outputs
`timescale 1ns/100ps
`default_nettype none
module pdc_checker
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	input wire logic o_reg_hit,
	input wire logic i_output_hs_tick,
	input wire logic o_first_output_clock,
	input wire logic [20:0] o_first_output_ratio,
	input wire logic [20:0] o_second_output_ratio,
	input wire logic o_first_output_setting_legal,
	input wire logic o_second_output_setting_legal
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	property p_rd_answer; i_reg_rd |=> o_reg_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_wr_rd;
		i_reg_wr && i_reg_addr == 8'h20 ##1 i_reg_rd && !i_reg_wr && i_reg_addr == 8'h20
		|=> o_reg_rdata == $past(i_reg_wdata, 2);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("write not read back");
	property p_unmapped; i_reg_rd && !o_reg_hit |=> o_reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_upper_res;
		i_reg_rd && (i_reg_addr == 8'h1f || i_reg_addr == 8'h22) |=> o_reg_rdata[7:4] == 4'h0;
	endproperty
	a_upper_res: assert property (p_upper_res) else $error("upper reserved bits set");
	property p_fb_res; i_reg_rd && i_reg_addr == 8'h28 |=> !o_reg_rdata[4]; endproperty
	a_fb_res: assert property (p_fb_res) else $error("feedback bit 4 set");
	property p_legal1;
		o_first_output_ratio != 21'h0 |->
		o_first_output_setting_legal == (o_first_output_ratio == 21'h1 || !o_first_output_ratio[0]);
	endproperty
	a_legal1: assert property (p_legal1) else $error("first legality wrong");
	property p_legal2;
		o_second_output_ratio != 21'h0 |->
		o_second_output_setting_legal == (o_second_output_ratio == 21'h1 || !o_second_output_ratio[0]);
	endproperty
	a_legal2: assert property (p_legal2) else $error("second legality wrong");
	property p_tick1; o_first_output_clock |-> $past(i_output_hs_tick); endproperty
	a_tick1: assert property (p_tick1) else $error("output tick without enable");
endmodule
bind pll_divider_config pdc_checker u_chk (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
	.i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_reg_hit, .i_output_hs_tick, .o_first_output_clock,
	.o_first_output_ratio, .o_second_output_ratio, .o_first_output_setting_legal,
	.o_second_output_setting_legal);
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench of the divider configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic hs_t = 1'b0;
	logic vco_t = 1'b0;
	logic [7:0] fb_lo = 8'h01;
	logic [7:0] rdata;
	logic rvalid;
	logic hit;
	wire [2:0] ticks;
	logic [20:0] ratio1;
	logic [20:0] ratio2;
	logic legal1;
	logic legal2;
	int fails = 0;
	int comparisons = 0;
	logic [7:0] d;
	int n;
	always #50 clk = ~clk;
	pll_divider_config u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.o_reg_hit(hit), .i_output_hs_tick(hs_t), .i_vco_tick(vco_t),
		.i_feedback_lowspeed_low(fb_lo), .o_first_output_clock(ticks[0]),
		.o_second_output_clock(ticks[1]), .o_phase_detector_tick(ticks[2]),
		.o_first_output_ratio(ratio1), .o_second_output_ratio(ratio2),
		.o_first_output_setting_legal(legal1), .o_second_output_setting_legal(legal2));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] v);
		wr = 1'b1;
		addr = a;
		wdata = v;
		@(negedge clk);
		wr = 1'b0;
		// Idle edge so a next call never lowers and raises wr together
		@(negedge clk);
	endtask
	task rd_reg(input logic [7:0] a, output logic [7:0] v);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		chk(rvalid, 1'b1);
		v = rdata;
		@(negedge clk);
	endtask
	// Cycles between two ticks of one output, waits bounded
	task period(input int s, output int c);
		c = 0;
		for (int k = 0; k < 300 && ticks[s] !== 1'b1; k++)
			@(negedge clk);
		@(negedge clk);
		for (c = 1; c < 300 && ticks[s] !== 1'b1; c++)
			@(negedge clk);
	endtask
	task t_reset;
		static logic [7:0] a[8] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h29};
		static logic [7:0] e[8] = '{8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'hc0, 8'h00};
		for (int i = 0; i < 8; i++)
		begin
			rd_reg(a[i], d);
			chk(d, e[i]);
		end
		chk(ratio1, 21'h32);
		chk(legal2, 1'b1);
	endtask
	task t_access;
		static logic [7:0] a[9] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h29, 8'h25};
		static logic [7:0] e[9] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hef, 8'hff, 8'h00};
		// Write then read back to back, as the port allows
		for (int i = 0; i < 9; i++)
		begin
			wr = 1'b1;
			addr = a[i];
			wdata = 8'hff;
			@(negedge clk);
			wr = 1'b0;
			rd = 1'b1;
			@(negedge clk);
			rd = 1'b0;
			chk(rvalid, 1'b1);
			chk(rdata, e[i]);
			chk(hit, (i < 8) ? 1'b1 : 1'b0);
		end
	endtask
	task t_reset_again;
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
	endtask
	task t_ratio;
		wr_reg(8'h1f, 8'h00);
		wr_reg(8'h20, 8'h00);
		wr_reg(8'h21, 8'h02);
		wr_reg(8'h22, 8'h00);
		wr_reg(8'h23, 8'h00);
		wr_reg(8'h24, 8'h00);
		@(negedge clk);
		chk(ratio1, 21'h3);
		chk(legal1, 1'b0);
		chk(ratio2, 21'h1);
		chk(legal2, 1'b1);
		wr_reg(8'h21, 8'h03);
		wr_reg(8'h24, 8'h01);
		hs_t = 1'b1;
		repeat (20) @(negedge clk);
		period(0, n);
		chk(n, 4);
		period(1, n);
		chk(n, 2);
	endtask
	task t_feedback;
		wr_reg(8'h29, 8'h00);
		vco_t = 1'b1;
		for (int c = 0; c < 8; c++)
		begin
			wr_reg(8'h28, 8'(c << 5));
			repeat (60) @(negedge clk);
			period(2, n);
			chk(n, (c + 4) * 2);
		end
		// Low-speed term is taken at its next wrap
		fb_lo = 8'h02;
		repeat (60) @(negedge clk);
		period(2, n);
		chk(n, 33);
	endtask
	initial
	begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_access();
		t_reset_again();
		t_ratio();
		t_feedback();
		give_verdict();
	end
	initial
	begin
		#500000;
		fails++;
		give_verdict();
	end
endmodule
`default_nettype wire
